// ==== pst_cfg.svh ====
// Constants for the program space table access path
`ifndef PST_CFG_SVH
`define PST_CFG_SVH
`define PST_PAGE_W 8
`define PST_CFG_SPACE_BIT 7
`define PST_OFFS_W 16
`define PST_PADDR_W 24
`define PST_LOW_W 16
`define PST_HIGH_W 8
`define PST_RD_LATENCY 2
`define PST_PAGE_RESET 8'h00
`endif

// ==== pst_lane_fmt.sv ====
// Formats one program memory read into the destination data word
`timescale 1ns/1ns
`include "pst_cfg.svh"
module pst_lane_fmt (
   input wire logic high_in,
   input wire logic byte_mode_in,
   input wire logic byte_sel_in,
   input wire logic [`PST_LOW_W-1:0] low_word_in,
   input wire logic [`PST_HIGH_W-1:0] high_byte_in,
   output logic [15:0] data_out
);
   logic [15:0] src;
   always_comb begin
      // Upper space is a 16-bit word whose top byte is phantom zero
      if (high_in) begin
         src = {8'h00, high_byte_in};
      end else begin
         src = low_word_in;
      end
      if (!byte_mode_in) begin
         data_out = src;
      end else if (byte_sel_in) begin
         data_out = {8'h00, src[15:8]};
      end else begin
         data_out = {8'h00, src[7:0]};
      end
   end
endmodule

// ==== pst_pkg.sv ====
// Types for the program space table access path
`include "pst_cfg.svh"
package pst_pkg;
   typedef enum logic [1:0] {
      PST_OP_READ_LOW,
      PST_OP_READ_HIGH,
      PST_OP_WRITE_LOW,
      PST_OP_WRITE_HIGH
   } pst_op_t;
   typedef struct packed {
      pst_op_t op;
      logic byte_mode;
      logic [`PST_OFFS_W-1:0] offset;
      logic [15:0] wdata;
   } pst_req_t;
   typedef struct packed {
      logic [`PST_PADDR_W-1:0] addr;
      logic cfg_space;
      logic high_space;
      logic [1:0] lane_en;
      logic [15:0] wdata;
   } pst_mem_t;
endpackage

// ==== pst_prog_mem_model.sv ====
// Program memory model that answers table reads after a fixed latency
`timescale 1ns/1ns
module pst_prog_mem_model #(
   parameter int RD_LATENCY = 2
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic mem_rd_in,
   input wire pst_pkg::pst_mem_t mem_in,
   output logic [15:0] low_out,
   output logic [7:0] high_out
);
   logic [3:0] cnt_q;
   logic [23:0] word_q;
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         cnt_q <= 4'h0;
         word_q <= 24'h000000;
      end else if (mem_rd_in) begin
         cnt_q <= 4'(RD_LATENCY);
         // Word depends on full address and space, so a bad map shows
         word_q <= {mem_in.addr[7:0] ^ 8'h5a, mem_in.addr[23:8]} ^
            (mem_in.cfg_space ? 24'ha5c3e1 : 24'h000000);
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end else begin
         // Stale data flips every cycle once cnt_q reaches zero, so a late sample matches only on every other cycle
         word_q <= ~word_q;
      end
   end
   assign low_out = word_q[15:0];
   assign high_out = word_q[23:16];
endmodule

// ==== pst_table_access.sv ====
// Table read and write path between core and program memory
`timescale 1ns/1ns
`include "pst_cfg.svh"
module pst_table_access #(
   parameter int RD_LATENCY = `PST_RD_LATENCY
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic req_valid_in,
   input wire pst_pkg::pst_req_t req_in,
   input wire logic page_we_in,
   input wire logic [`PST_PAGE_W-1:0] page_wdata_in,
   input wire logic [`PST_LOW_W-1:0] mem_low_in,
   input wire logic [`PST_HIGH_W-1:0] mem_high_in,
   output logic req_ready_out,
   output logic done_out,
   output logic [15:0] rdata_out,
   output logic [`PST_PAGE_W-1:0] table_page_select_out,
   output logic mem_rd_out,
   output logic mem_wr_out,
   output pst_pkg::pst_mem_t mem_out
);
   typedef enum logic [1:0] {
      PST_IDLE,
      PST_WAIT,
      PST_DONE
   } pst_state_t;
   typedef struct packed {
      pst_state_t state;
      logic [`PST_PAGE_W-1:0] page;
      pst_pkg::pst_mem_t mem;
      logic rd;
      logic wr;
      logic is_write;
      logic byte_mode;
      logic byte_sel;
      logic [3:0] cnt;
      logic [15:0] rdata;
   } pst_regs_t;
   pst_regs_t r_q;
   pst_regs_t r_d;
   logic [15:0] fmt_data;
   logic is_high;
   logic is_wr;

   assign is_high = (req_in.op == pst_pkg::PST_OP_READ_HIGH) ||
      (req_in.op == pst_pkg::PST_OP_WRITE_HIGH);
   assign is_wr = (req_in.op == pst_pkg::PST_OP_WRITE_LOW) ||
      (req_in.op == pst_pkg::PST_OP_WRITE_HIGH);

   pst_lane_fmt u_fmt (
      .high_in(r_q.mem.high_space),
      .byte_mode_in(r_q.byte_mode),
      .byte_sel_in(r_q.byte_sel),
      .low_word_in(mem_low_in),
      .high_byte_in(mem_high_in),
      .data_out(fmt_data)
   );

   always_comb begin
      r_d = r_q;
      r_d.rd = 1'b0;
      r_d.wr = 1'b0;
      if (page_we_in) begin
         r_d.page = page_wdata_in;
      end
      unique case (r_q.state)
         PST_IDLE: begin
            if (req_valid_in) begin
               // Page concatenated above offset: word address, step of 2
               r_d.mem.addr = {r_q.page, req_in.offset[15:1], 1'b0};
               r_d.mem.cfg_space = r_q.page[`PST_CFG_SPACE_BIT];
               r_d.mem.high_space = is_high;
               r_d.byte_sel = req_in.offset[0];
               r_d.byte_mode = req_in.byte_mode;
               r_d.is_write = is_wr;
               // Byte writes steer the byte to its lane
               if (req_in.byte_mode) begin
                  r_d.mem.lane_en = req_in.offset[0] ? 2'h2 : 2'h1;
                  r_d.mem.wdata = {req_in.wdata[7:0], req_in.wdata[7:0]};
               end else begin
                  r_d.mem.lane_en = 2'h3;
                  r_d.mem.wdata = req_in.wdata;
               end
               // Phantom byte of upper space is never written
               if (is_high) begin
                  r_d.mem.lane_en[1] = 1'b0;
               end
               r_d.rd = !is_wr;
               r_d.wr = is_wr;
               r_d.cnt = 4'(RD_LATENCY - 1);
               r_d.state = PST_WAIT;
            end
         end
         PST_WAIT: begin
            // Memory data sampled after fixed latency
            if (r_q.cnt == 4'h0) begin
               if (!r_q.is_write) begin
                  r_d.rdata = fmt_data;
               end
               r_d.state = PST_DONE;
            end else begin
               r_d.cnt = r_q.cnt - 4'h1;
            end
         end
         PST_DONE: begin
            r_d.state = PST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         r_q <= '0;
         r_q.page <= `PST_PAGE_RESET;
         r_q.state <= PST_IDLE;
      end else begin
         r_q <= r_d;
      end
   end

   assign req_ready_out = (r_q.state == PST_IDLE);
   assign done_out = (r_q.state == PST_DONE);
   assign rdata_out = r_q.rdata;
   assign table_page_select_out = r_q.page;
   assign mem_rd_out = r_q.rd;
   assign mem_wr_out = r_q.wr;
   assign mem_out = r_q.mem;

   // Assertions
   sequence s_take;
      req_valid_in && req_ready_out;
   endsequence
   property p_multi_cycle;
      @(posedge clock_in) disable iff (rst_in)
      s_take |=> !done_out;
   endproperty
   a_multi_cycle: assert property (p_multi_cycle)
      else $error("table op finished in one cycle");
   property p_addr_even;
      @(posedge clock_in) disable iff (rst_in)
      mem_rd_out || mem_wr_out |-> mem_out.addr[0] == 1'b0;
   endproperty
   a_addr_even: assert property (p_addr_even)
      else $error("program address is odd");
   property p_page;
      @(posedge clock_in) disable iff (rst_in)
      s_take ##0 !page_we_in |=> mem_out.addr[23:16] == $past(r_q.page);
   endproperty
   a_page: assert property (p_page)
      else $error("page not taken from page register");
   property p_cfg;
      @(posedge clock_in) disable iff (rst_in)
      s_take |=> mem_out.cfg_space ==
         $past(r_q.page[`PST_CFG_SPACE_BIT]);
   endproperty
   a_cfg: assert property (p_cfg)
      else $error("space select mismatch");
   property p_high_space;
      @(posedge clock_in) disable iff (rst_in)
      s_take |=> mem_out.high_space == $past(is_high);
   endproperty
   a_high_space: assert property (p_high_space)
      else $error("wrong program space");
   property p_phantom_wr;
      @(posedge clock_in) disable iff (rst_in)
      mem_wr_out && mem_out.high_space |-> !mem_out.lane_en[1];
   endproperty
   a_phantom_wr: assert property (p_phantom_wr)
      else $error("phantom byte written");
   property p_phantom_rd;
      @(posedge clock_in) disable iff (rst_in)
      done_out && !r_q.is_write && r_q.mem.high_space |->
         rdata_out[15:8] == 8'h00;
   endproperty
   a_phantom_rd: assert property (p_phantom_rd)
      else $error("phantom byte not zero");
   property p_byte_sel;
      @(posedge clock_in) disable iff (rst_in)
      s_take |=> r_q.byte_sel == $past(req_in.offset[0]);
   endproperty
   a_byte_sel: assert property (p_byte_sel)
      else $error("byte select not from address bit 0");
   property p_byte_wr;
      @(posedge clock_in) disable iff (rst_in)
      mem_wr_out && r_q.byte_mode |-> mem_out.lane_en != 2'h3;
   endproperty
   a_byte_wr: assert property (p_byte_wr)
      else $error("byte write enabled both lanes");
   property p_word_rd;
      @(posedge clock_in) disable iff (rst_in)
      r_q.state == PST_WAIT && r_q.cnt == 4'h0 && !r_q.is_write &&
         !r_q.byte_mode && !r_q.mem.high_space |=>
         rdata_out == $past(mem_low_in);
   endproperty
   a_word_rd: assert property (p_word_rd)
      else $error("low word read mismatch");
endmodule

// ==== test_pst_table_access.sv ====
// Self-checking bench for the table access path
`timescale 1ns/1ns
module test_pst_table_access;
   localparam int LAT = 2;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic req_valid_in = 1'b0;
   pst_pkg::pst_req_t req_in = '0;
   logic page_we_in = 1'b0;
   logic [7:0] page_wdata_in = 8'h00;
   logic [15:0] mem_low_in;
   logic [7:0] mem_high_in;
   logic req_ready_out, done_out, mem_rd_out, mem_wr_out;
   logic [15:0] rdata_out;
   logic [7:0] table_page_select_out;
   pst_pkg::pst_mem_t mem_out;
   int miscompares = 0;
   int checks = 0;
   pst_table_access #(.RD_LATENCY(LAT)) pst_table_access_inst (
      .clock_in(clock_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
      .req_in(req_in), .page_we_in(page_we_in),
      .page_wdata_in(page_wdata_in), .mem_low_in(mem_low_in),
      .mem_high_in(mem_high_in), .req_ready_out(req_ready_out),
      .done_out(done_out), .rdata_out(rdata_out),
      .table_page_select_out(table_page_select_out),
      .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out), .mem_out(mem_out));
   pst_prog_mem_model #(.RD_LATENCY(LAT)) pst_prog_mem_model_inst (
      .clock_in(clock_in), .rst_in(rst_in), .mem_rd_in(mem_rd_out),
      .mem_in(mem_out), .low_out(mem_low_in), .high_out(mem_high_in));
   initial forever #5 clock_in = ~clock_in;
   function automatic logic [23:0] prog_word(logic [23:0] a, logic c);
      return {a[7:0] ^ 8'h5a, a[23:8]} ^ (c ? 24'ha5c3e1 : 24'h000000);
   endfunction
   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic run_op(logic [1:0] op, logic bm, logic [15:0] offs,
         logic [15:0] wd, logic [7:0] pg);
      logic [23:0] a, p;
      logic [15:0] exp;
      logic [1:0] lane;
      logic hi, wr, sel;
      int n;
      hi = op[0];
      wr = op[1];
      sel = offs[0];
      a = {pg, offs[15:1], 1'b0};
      p = prog_word(a, pg[7]);
      lane = (bm ? (sel ? 2'b10 : 2'b01) : 2'b11) & (hi ? 2'b01 : 2'b11);
      exp = hi ? ((bm && sel) ? 16'h0000 : {8'h00, p[23:16]})
         : (!bm ? p[15:0] : {8'h00, sel ? p[15:8] : p[7:0]});
      page_we_in = 1'b1;
      page_wdata_in = pg;
      @(posedge clock_in);
      #1 page_we_in = 1'b0;
      chk(table_page_select_out, pg);
      chk(req_ready_out, 1'b1);
      req_valid_in = 1'b1;
      req_in = '{pst_pkg::pst_op_t'(op), bm, offs, wd};
      @(posedge clock_in);
      #1 req_valid_in = 1'b0;
      chk({mem_rd_out, mem_wr_out}, {!wr, wr});
      chk(mem_out.addr, a);
      chk(mem_out.cfg_space, pg[7]);
      chk(mem_out.high_space, hi);
      if (wr)
         chk({mem_out.lane_en, mem_out.wdata},
            {lane, bm ? {wd[7:0], wd[7:0]} : wd});
      n = 1;
      while (done_out !== 1'b1 && n < 10) begin
         @(posedge clock_in);
         #1 n++;
      end
      chk(n, LAT + 1);
      if (!wr)
         chk(rdata_out, exp);
      @(posedge clock_in);
      #1;
   endtask
   initial begin
      #100000;
      miscompares++;
      close_out();
   end
   initial begin
      void'($urandom(32'h197bc873));
      repeat (8) @(posedge clock_in);
      #1 rst_in = 1'b0;
      chk({req_ready_out, done_out, mem_rd_out, mem_wr_out, rdata_out,
         table_page_select_out}, 28'h8000000);
      // Every op, both sizes, both byte selects; reads use page 8'h7f and writes page 8'h80, so only writes hit cfg space
      for (int i = 0; i < 16; i++)
         run_op(i[1:0], i[2], i[3] ? 16'hffff : 16'h0000, 16'hc33c,
            i[1] ? 8'h80 : 8'h7f);
      $display("corner test done");
      for (int i = 0; i < 60; i++)
         run_op(2'($urandom), 1'($urandom), 16'($urandom),
            16'($urandom), 8'($urandom));
      $display("random test done");
      close_out();
   end
endmodule
